// ==== rtl/supply_reset_supervisor.sv ====
// supply, reset and slow-clock supervisor with an ahb-lite register slave
`timescale 1ns/1ps
`include "supply_reset_params.svh"
module supply_reset_supervisor
    import supply_reset_pkg::*;
(
    // clock and own reset of the supply unit
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // analog detectors and oscillator status
    input wire logic por_io_low,
    input wire logic bod_core_low,
    input wire logic smon_io_low,
    input wire logic xtal_ready,
    // same-clock reset requests
    input wire logic wake_event,
    input wire logic watchdog_event,
    // external_reset_pin_n as three signals
    input wire logic external_reset_pin_n_i,
    output logic external_reset_pin_n_o,
    output logic external_reset_pin_n_oe,
    // resets and power controls
    output logic chip_reset,
    output logic core_reset,
    output logic power_switch_en,
    output logic regulator_en,
    output logic bod_en,
    output logic smon_en,
    output logic [3:0] smon_threshold,
    // clock controls
    output logic slow_rc_en,
    output logic xtal_osc_en,
    output logic slow_clk_sel_xtal,
    output logic [1:0] fast_rc_freq_sel,
    output logic main_system_clock_fast_rc,
    // interrupt
    output logic irq
);

    sup_state_t q;
    sup_state_t n;
    sense_t raw;
    sense_t s;
    logic sw_req;
    logic [3:0] w1c;
    logic [3:0] ev;
    logic [31:0] rd;
    logic [11:0] pulse_cyc;

    // ==========================================================
    // input synchronisers
    assign raw = '{por_low: por_io_low, bod_low: bod_core_low, smon_low: smon_io_low,
                   xtal_ready: xtal_ready, pin_level: external_reset_pin_n_i};

    level_sync #(.W($bits(sense_t))) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(raw),
        .settled(s)
    );

    // length of the shaped pin pulse: 256 cycles per step of pulse_len
    assign pulse_cyc = {q.pulse_len, 8'hFF};

    // ==========================================================
    // next-state logic
    always_comb begin
        n = q;
        sw_req = 1'b0;
        w1c = 4'h0;
        ev = 4'h0;
        rd = 32'h0000_0000;

        // data phase of a write; registers live in this unit so core loss keeps them
        // io-domain configuration
        if (q.ap_wr) begin
            if (q.ap_addr == `OFF_CTRL) begin
                n.bod_off = hwdata[`CTRL_BOD_OFF];
                n.smon_on = hwdata[`CTRL_SMON_ON];
                n.smon_samp = hwdata[`CTRL_SMON_SAMP];
                n.xtal_req = hwdata[`CTRL_XTAL_EN];
                n.smon_thr = hwdata[`CTRL_THR_MSB:`CTRL_THR_LSB];
                n.slow_req = hwdata[`CTRL_SLOW_XTAL];
                if (hwdata[`CTRL_FRC_MSB:`CTRL_FRC_LSB] != `FRC_BAD) begin
                    n.frc = hwdata[`CTRL_FRC_MSB:`CTRL_FRC_LSB];
                end
            end else if (q.ap_addr == `OFF_SAMPLE) begin
                n.ratio = hwdata[10:0];
            end else if (q.ap_addr == `OFF_PIN) begin
                n.pulse_len = hwdata[3:0];
            end else if (q.ap_addr == `OFF_IRQ_STAT) begin
                w1c = hwdata[3:0];
            end else if (q.ap_addr == `OFF_IRQ_MASK) begin
                n.irq_mask = hwdata[3:0];
            end else if (q.ap_addr == `OFF_CMD) begin
                sw_req = hwdata[`CMD_CORE_RST];
            end
        end

        // read mux; unmapped offsets read zero
        // cause visible to software, read-only
        if (q.ap_addr == `OFF_CTRL) begin
            rd = {21'h00_0000, q.frc, q.slow_req, q.smon_thr, q.xtal_req, q.smon_samp,
                  q.smon_on, q.bod_off};
        end else if (q.ap_addr == `OFF_STATUS) begin
            rd = {24'h00_0000, s.bod_low, s.pin_level, q.slow_xtal, s.smon_low, 1'b0,
                  q.cause};
        end else if (q.ap_addr == `OFF_SAMPLE) begin
            rd = {21'h00_0000, q.ratio};
        end else if (q.ap_addr == `OFF_PIN) begin
            rd = {28'h000_0000, q.pulse_len};
        end else if (q.ap_addr == `OFF_IRQ_STAT) begin
            rd = {28'h000_0000, q.irq_stat};
        end else if (q.ap_addr == `OFF_IRQ_MASK) begin
            rd = {28'h000_0000, q.irq_mask};
        end

        // address phase; reads take one wait state so a write just before is seen
        n.ap_wr = 1'b0;
        n.ready = 1'b1;
        if (q.ap_rd) begin
            n.ap_rd = 1'b0;
            n.rdata = rd;
        end else if (hsel && hready && htrans[1] && hsize == 3'h2) begin
            n.ap_addr = haddr[7:0];
            if (hwrite) begin
                n.ap_wr = 1'b1;
            end else begin
                n.ap_rd = 1'b1;
                n.ready = 1'b0;
            end
        end

        // brownout enable from the mode setting
        n.bod_on = !n.bod_off;

        // ==========================================================
        // start-up and reset sequencer
        case (q.st)
            SEQ_OFF: begin
                if (!s.por_low) begin
                    n.st = SEQ_SWITCH;
                    n.cnt = `SWITCH_CYC - 16'h0001;
                    n.pwr_sw = 1'b1;
                end
            end
            SEQ_SWITCH: begin
                if (q.cnt == 16'h0000) begin
                    n.st = SEQ_VREG;
                    n.cnt = `VREG_CYC - 16'h0001;
                    n.vreg = 1'b1;
                end else begin
                    n.cnt = q.cnt - 16'h0001;
                end
            end
            SEQ_VREG: begin
                if (q.cnt == 16'h0000) begin
                    n.st = SEQ_HOLD;
                    n.cnt = {4'h0, pulse_cyc};
                end else begin
                    n.cnt = q.cnt - 16'h0001;
                end
            end
            SEQ_HOLD: begin
                if (n.bod_on && s.bod_low) begin
                    n.cnt = {4'h0, pulse_cyc};
                end else if (q.cnt == 16'h0000) begin
                    n.st = SEQ_RUN;
                    n.core_rst = 1'b0;
                    n.pin_oe = 1'b0;
                    n.pin_armed = 1'b0;
                    n.cause = q.pend;
                end else begin
                    n.cnt = q.cnt - 16'h0001;
                end
            end
            SEQ_RUN: begin
                // arm user detection only after the pin is seen high again
                if (s.pin_level) begin
                    n.pin_armed = 1'b1;
                end
                // brownout has priority, then watchdog, software, wake, user
                if (n.bod_on && s.bod_low) begin
                    n.pend = `CAUSE_GENERAL;
                    ev[`IRQ_BOD] = 1'b1;
                end else if (watchdog_event) begin
                    n.pend = `CAUSE_WATCHDOG;
                end else if (sw_req) begin
                    n.pend = `CAUSE_SOFTWARE;
                end else if (wake_event) begin
                    n.pend = `CAUSE_WAKEUP;
                end else if (q.pin_armed && !s.pin_level) begin
                    n.pend = `CAUSE_USER;
                    ev[`IRQ_USER] = 1'b1;
                end
                if ((n.bod_on && s.bod_low) || watchdog_event || sw_req || wake_event ||
                    (q.pin_armed && !s.pin_level)) begin
                    // shaped pulse on the pin while the core is held
                    n.st = SEQ_HOLD;
                    n.cnt = {4'h0, pulse_cyc};
                    n.core_rst = 1'b1;
                    n.pin_oe = 1'b1;
                end
            end
            default: begin
                n.st = SEQ_OFF;
            end
        endcase

        n.chip_rst = s.por_low;
        if (s.por_low) begin
            n.st = SEQ_OFF;
            n.pend = `CAUSE_GENERAL;
            n.core_rst = 1'b1;
            n.pwr_sw = 1'b0;
            n.vreg = 1'b0;
            n.pin_oe = 1'b1;
            n.pin_armed = 1'b0;
        end

        // ==========================================================
        // supply monitor enable and sampling
        // enable and threshold from the mode setting
        // sampled mode: one enabled cycle per ratio+1 cycles
        if (!n.smon_on) begin
            n.smon_en = 1'b0;
            n.samp_cnt = n.ratio;
        end else if (!n.smon_samp) begin
            n.smon_en = 1'b1;
            n.samp_cnt = n.ratio;
        end else if (q.samp_cnt == 11'h000) begin
            n.smon_en = 1'b1;
            n.samp_cnt = n.ratio;
        end else begin
            n.smon_en = 1'b0;
            n.samp_cnt = q.samp_cnt - 11'h001;
        end
        if (q.smon_en && s.smon_low) begin
            ev[`IRQ_SMON] = 1'b1;
        end

        // ==========================================================
        // slow clock source; switch to crystal only once it is running
        // rc by default, crystal on request
        if (!n.slow_req) begin
            n.slow_xtal = 1'b0;
        end else if (s.xtal_ready && !q.slow_xtal && q.xtal_on) begin
            n.slow_xtal = 1'b1;
            ev[`IRQ_XTAL] = 1'b1;
        end
        n.xtal_on = n.xtal_req || n.slow_req || n.slow_xtal;
        n.rc_on = !n.slow_xtal;

        // interrupt: set wins over a write-one clear
        n.irq_stat = (q.irq_stat & ~w1c) | ev;
        n.irq = |(n.irq_stat & n.irq_mask);
    end

    // ==========================================================
    // state register, reset by the unit's own reset only
    // independent of the core reset it drives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{st: SEQ_OFF, cnt: 16'h0000, cause: `CAUSE_GENERAL,
                   pend: `CAUSE_GENERAL, bod_off: 1'b0, smon_on: 1'b0, smon_samp: 1'b0,
                   xtal_req: 1'b0, slow_req: 1'b0, smon_thr: `SMON_THR_RST,
                   frc: `FRC_4MHZ, ratio: `RATIO_RST, pulse_len: `PULSE_LEN_RST,
                   samp_cnt: `RATIO_RST, smon_en: 1'b0, slow_xtal: 1'b0, xtal_on: 1'b0,
                   rc_on: 1'b1, bod_on: 1'b1, irq_stat: 4'h0, irq_mask: `IRQ_MASK_RST,
                   irq: 1'b0, chip_rst: 1'b1, core_rst: 1'b1, pwr_sw: 1'b0, vreg: 1'b0,
                   pin_oe: 1'b1, pin_armed: 1'b0, mck_frc: 1'b1, ap_wr: 1'b0,
                   ap_rd: 1'b0, ap_addr: 8'h00, ready: 1'b1, rdata: 32'h0000_0000};
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs straight from the state register, apart from hresp and the pin level, which are tied low
    assign hreadyout = q.ready;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign external_reset_pin_n_o = 1'b0;
    assign external_reset_pin_n_oe = q.pin_oe;
    assign chip_reset = q.chip_rst;
    assign core_reset = q.core_rst;
    assign power_switch_en = q.pwr_sw;
    assign regulator_en = q.vreg;
    assign bod_en = q.bod_on;
    assign smon_en = q.smon_en;
    assign smon_threshold = q.smon_thr;
    assign slow_rc_en = q.rc_on;
    assign xtal_osc_en = q.xtal_on;
    assign slow_clk_sel_xtal = q.slow_xtal;
    assign fast_rc_freq_sel = q.frc;
    // no other master clock source is modelled here
    assign main_system_clock_fast_rc = q.mck_frc;
    assign irq = q.irq;

    // ==========================================================
    // assertions
    a_por_holds_chip: assert property (@(posedge hclk) disable iff (!hresetn)
        s.por_low |=> (q.chip_rst && q.core_rst && q.st == SEQ_OFF))
        else $error("power-on low did not hold the chip");
    a_bod_switch_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (q.ap_wr && q.ap_addr == `OFF_CTRL) |=> (q.bod_on == !$past(hwdata[`CTRL_BOD_OFF])))
        else $error("brownout enable did not follow the mode setting");
    a_bod_core_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        (q.bod_on && s.bod_low && q.st == SEQ_RUN && !s.por_low && !q.ap_wr)
        |=> (q.core_rst && q.st == SEQ_HOLD))
        else $error("brownout did not reset the core");
    a_smon_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
        (q.ap_wr && q.ap_addr == `OFF_CTRL && !hwdata[`CTRL_SMON_ON])
        |=> (!q.smon_en && q.smon_thr == $past(hwdata[`CTRL_THR_MSB:`CTRL_THR_LSB])))
        else $error("supply monitor setting not applied");
    a_smon_sampled: assert property (@(posedge hclk) disable iff (!hresetn)
        (q.smon_en && q.smon_on && q.smon_samp && q.ratio == 11'h003 && !q.ap_wr)
        ##1 !q.ap_wr |=> (!q.smon_en ##1 !q.smon_en ##1 q.smon_en))
        else $error("sampled monitor period wrong");
    a_cause_release: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(q.core_rst) |-> (q.cause == $past(q.pend) && q.st == SEQ_RUN))
        else $error("reset cause not latched at release");
    a_pin_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        (q.st == SEQ_HOLD) |-> (q.pin_oe && q.core_rst))
        else $error("pin not driven during core reset");
    a_xtal_switch: assert property (@(posedge hclk) disable iff (!hresetn)
        (q.slow_req && s.xtal_ready && q.xtal_on && !q.slow_xtal && !q.ap_wr)
        |=> (q.slow_xtal && !q.rc_on && q.irq_stat[`IRQ_XTAL]))
        else $error("slow clock switch or rc disable missing");
    a_power_order: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(q.core_rst) |-> ($past(q.vreg) && $past(q.pwr_sw) && $past(q.st) == SEQ_HOLD))
        else $error("core released before power was up");
    a_frc_code: assert property (@(posedge hclk) disable iff (!hresetn)
        q.frc != `FRC_BAD)
        else $error("reserved fast rc code stored");
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        q.irq == |(q.irq_stat & q.irq_mask))
        else $error("interrupt output does not match status and mask");

endmodule

// ==== rtl/supply_reset_params.svh ====
// constants for the supply and reset supervisor: offsets, fields, reset values, timing
`ifndef SUPPLY_RESET_PARAMS_SVH
`define SUPPLY_RESET_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_SAMPLE 8'h08
`define OFF_PIN 8'h0C
`define OFF_IRQ_STAT 8'h10
`define OFF_IRQ_MASK 8'h14
`define OFF_CMD 8'h18

// ==========================================================
// supply_mode_config field positions
`define CTRL_BOD_OFF 0
`define CTRL_SMON_ON 1
`define CTRL_SMON_SAMP 2
`define CTRL_XTAL_EN 3
`define CTRL_THR_LSB 4
`define CTRL_THR_MSB 7
`define CTRL_SLOW_XTAL 8
`define CTRL_FRC_LSB 9
`define CTRL_FRC_MSB 10
`define CMD_CORE_RST 0

// ==========================================================
// reset cause codes
`define CAUSE_GENERAL 3'h0
`define CAUSE_WAKEUP 3'h1
`define CAUSE_WATCHDOG 3'h2
`define CAUSE_SOFTWARE 3'h3
`define CAUSE_USER 3'h4

// ==========================================================
// interrupt status bits
`define IRQ_BOD 0
`define IRQ_SMON 1
`define IRQ_USER 2
`define IRQ_XTAL 3
`define IRQ_W 4

// ==========================================================
// fast rc frequency codes
`define FRC_4MHZ 2'h0
`define FRC_8MHZ 2'h1
`define FRC_12MHZ 2'h2
`define FRC_BAD 2'h3

// ==========================================================
// reset values
`define SMON_THR_RST 4'h0
`define RATIO_RST 11'h000
`define PULSE_LEN_RST 4'h0
`define IRQ_MASK_RST 4'h0

// ==========================================================
// timing
`define CLK_MHZ 40
`define SWITCH_SETTLE_NS 1000
`define VREG_SETTLE_NS 2000
`define SWITCH_CYC 16'((`SWITCH_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define VREG_CYC 16'((`VREG_SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/supply_reset_pkg.sv ====
// types shared by the supply and reset supervisor
package supply_reset_pkg;

    // ==========================================================
    // start-up and reset sequencer states
    typedef enum logic [4:0] {
        SEQ_OFF = 5'h01,
        SEQ_SWITCH = 5'h02,
        SEQ_VREG = 5'h04,
        SEQ_HOLD = 5'h08,
        SEQ_RUN = 5'h10
    } seq_t;

    // ==========================================================
    // analog and pin inputs that pass the synchroniser
    typedef struct packed {
        logic por_low;
        logic bod_low;
        logic smon_low;
        logic xtal_ready;
        logic pin_level;
    } sense_t;

    // ==========================================================
    // whole state of the supervisor
    typedef struct packed {
        seq_t st;
        logic [15:0] cnt;
        logic [2:0] cause;
        logic [2:0] pend;
        logic bod_off;
        logic smon_on;
        logic smon_samp;
        logic xtal_req;
        logic slow_req;
        logic [3:0] smon_thr;
        logic [1:0] frc;
        logic [10:0] ratio;
        logic [3:0] pulse_len;
        logic [10:0] samp_cnt;
        logic smon_en;
        logic slow_xtal;
        logic xtal_on;
        logic rc_on;
        logic bod_on;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic irq;
        logic chip_rst;
        logic core_rst;
        logic pwr_sw;
        logic vreg;
        logic pin_oe;
        logic pin_armed;
        logic mck_frc;
        logic ap_wr;
        logic ap_rd;
        logic [7:0] ap_addr;
        logic ready;
        logic [31:0] rdata;
    } sup_state_t;

endpackage

// ==== rtl/level_sync.sv ====
// three-stage synchroniser that passes a level once stages two and three agree
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // raw and settled levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] settled
);

    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;
    logic [W-1:0] settled_q;

    // ==========================================================
    // per-bit chain; ff1 feeds only ff2 to keep metastability contained
    // reset to high so supply-low and pin-idle levels read safe until real levels arrive
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ff1_q[i] <= 1'b1;
                ff2_q[i] <= 1'b1;
                ff3_q[i] <= 1'b1;
                settled_q[i] <= 1'b1;
            end else begin
                ff1_q[i] <= raw[i];
                ff2_q[i] <= ff1_q[i];
                ff3_q[i] <= ff2_q[i];
                if (ff2_q[i] == ff3_q[i]) begin
                    settled_q[i] <= ff3_q[i];
                end
            end
        end
    end

    assign settled = settled_q;

endmodule

// ==== test/tb.sv ====
// self-checking bench for the supply and reset supervisor
`timescale 1ns/1ps
`include "supply_reset_params.svh"
module tb;
    // ==========================================================
    // stimulus and observed signals
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0, fast_rc_freq_sel;
    logic [2:0] hsize = 0;
    logic por_io_low = 1, bod_core_low = 0, smon_io_low = 0, xtal_ready = 0;
    logic wake_event = 0, watchdog_event = 0, btn_n = 1;
    logic external_reset_pin_n_i, external_reset_pin_n_o, external_reset_pin_n_oe;
    logic chip_reset, core_reset, power_switch_en, regulator_en, bod_en, smon_en;
    logic slow_rc_en, xtal_osc_en, slow_clk_sel_xtal, main_system_clock_fast_rc, irq;
    logic [3:0] smon_threshold;
    int miscompares = 0, checked = 0;
    // one slave only, so its ready is the bus ready
    assign hready = hreadyout;
    // open-drain pin: the block pulls low, the button otherwise sets the level
    assign external_reset_pin_n_i = external_reset_pin_n_oe ? 1'b0 : btn_n;
    always #12.5 hclk = ~hclk;
    supply_reset_supervisor i_supply_reset_supervisor (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .por_io_low, .bod_core_low, .smon_io_low, .xtal_ready, .wake_event,
        .watchdog_event, .external_reset_pin_n_i, .external_reset_pin_n_o,
        .external_reset_pin_n_oe, .chip_reset, .core_reset, .power_switch_en,
        .regulator_en, .bod_en, .smon_en, .smon_threshold, .slow_rc_en, .xtal_osc_en,
        .slow_clk_sel_xtal, .fast_rc_freq_sel, .main_system_clock_fast_rc, .irq);
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // single word transfer; ready looked at mid-cycle, where it stands until the edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {24'h0000_00, a};
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        r = hrdata;
        // let the closing edge's updates land before callers look at outputs
        @(negedge hclk);
    endtask
    task automatic wait_core(input logic v);
        repeat (3000) if (core_reset !== v) @(posedge hclk);
        chk(32'(core_reset), 32'(v));
    endtask
    // a core reset is held with the pin pulled, then the cause is readable
    task automatic cause_after(input logic [2:0] c);
        wait_core(1);
        chk(32'(external_reset_pin_n_oe), 32'h0000_0001); // pin pulse
        wait_core(0);
        bus(0, `OFF_STATUS, 0);
        chk(32'(r[2:0]), 32'(c)); // cause code
    endtask
    task automatic settle();
        repeat (8) @(posedge hclk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_startup();
        chk({bod_en, smon_en, slow_rc_en, xtal_osc_en, slow_clk_sel_xtal, fast_rc_freq_sel,
            main_system_clock_fast_rc, chip_reset, core_reset, irq}, 11'h5_0E);
        por_io_low <= 0;
        repeat (60) if (power_switch_en !== 1'b1) @(posedge hclk);
        chk({power_switch_en, regulator_en, core_reset}, 3'h5); // switches first
        repeat (100) if (regulator_en !== 1'b1) @(posedge hclk);
        chk({regulator_en, core_reset}, 2'h3); // regulator before release
        cause_after(`CAUSE_GENERAL);
    endtask
    task automatic t_events();
        bus(1, `OFF_CMD, 1);
        cause_after(`CAUSE_SOFTWARE); // software
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            watchdog_event <= (i == 0);
            wake_event <= (i == 1);
            btn_n <= (i != 2);
            settle();
            watchdog_event <= 0;
            wake_event <= 0;
            btn_n <= 1;
            cause_after(i == 0 ? `CAUSE_WATCHDOG : i == 1 ? `CAUSE_WAKEUP : `CAUSE_USER);
        end
    endtask
    task automatic t_brownout();
        bod_core_low <= 1;
        settle();
        chk(32'(core_reset), 1); // brownout resets core
        bod_core_low <= 0;
        cause_after(`CAUSE_GENERAL); // general cause
        bus(1, `OFF_CTRL, 1);
        bod_core_low <= 1;
        repeat (12) @(posedge hclk);
        chk({bod_en, core_reset}, 0); // detector switched off
        bod_core_low <= 0;
        bus(1, `OFF_CTRL, 0);
    endtask
    task automatic t_config();
        int n;
        xtal_ready <= 1;
        bus(1, `OFF_CTRL, 32'h0000_05AA);
        settle();
        chk({smon_en, smon_threshold, fast_rc_freq_sel, xtal_osc_en}, 8'hD5);
        chk({slow_clk_sel_xtal, slow_rc_en}, 2'h2); // rc stopped
        bus(1, `OFF_CTRL, 32'h0000_07AA);
        chk(32'(fast_rc_freq_sel), 2); // bad code refused
        bus(1, `OFF_CTRL, 32'h0000_03AA);
        chk(32'(fast_rc_freq_sel), 1); // 8 MHz
        bus(1, `OFF_IRQ_MASK, 32'h0000_0008);
        chk(32'(irq), 1); // switch event raises interrupt
        bus(1, `OFF_IRQ_STAT, 32'h0000_0008);
        chk(32'(irq), 0); // cleared, brownout bit masked
        bus(1, `OFF_CTRL, 0);
        settle();
        chk({slow_clk_sel_xtal, slow_rc_en, xtal_osc_en, smon_en}, 4'h4); // back on rc
        bus(1, `OFF_SAMPLE, 3);
        bus(1, `OFF_CTRL, 32'h0000_0006);
        settle();
        n = 0;
        repeat (40) begin
            @(posedge hclk);
            n += int'(smon_en === 1'b1);
        end
        chk(n, 10); // one cycle in four
        chk({hresp, external_reset_pin_n_o}, 0); // open-drain pin, okay response
        bus(0, 8'h1C, 0);
        chk(r, 0); // unmapped reads zero
    endtask
    // ==========================================================
    // sequence, watchdog and verdict
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        t_startup();
        t_events();
        t_brownout();
        t_config();
        por_io_low <= 1;
        settle();
        chk({chip_reset, core_reset}, 2'h3); // low io supply resets chip
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        complete_run();
    end
endmodule
